/* core/fpe_flash_seq.sv */
/*
 * flash page erase / row program sequencer: control, unlock, holding buffer, status and interrupt
 * assumes bus strobes and table writes come from logic on clk; rst_n may be asynchronous
 */
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Function
// R01: software erases the whole eight-row page, saving its 512 instructions first.
// R02: page erase uses op 0010 with erase selector and permit bit set.
// R03: software gives the page start address by a table write to it.
// R04: only key 0x55 then 0xAA followed by go arms an operation.
// R05: go bit starts the operation, stalls the CPU, clears itself at the end.
// R06: software fills the 64-instruction holding buffer before a row program.
// R07: row program uses op 0001, erase selector clear, permit bit set.
// R08: row program writes the buffered row, stalls, then clears go.
// R09: software repeats buffer load and row program until the page is rewritten.
// R10: any operation needs the key sequence immediately before the go bit.
// R11: software puts two no-operations after setting the go bit.
// R12: page erase setup writes control value 0x4042.
// R13: row program setup writes control value 0x4001.
// R14: software holds low-priority interrupts off across keys and go.
// R15: each instruction loads by low-word write then high-byte write with increment.
// R16: fault flag sets on improper go attempt, stays clear on normal completion.
// R17: with permit bit clear, no program or erase happens.
// R18: only the listed erase and program codes run; others do nothing.
// R19: durations are cycle counts; control and key writes ignored while go set.
module fpe_flash_seq #(
	parameter int BUF_DEPTH = fpe_pkg::BUF_DEPTH,
	parameter int CYC_BULK  = fpe_pkg::CYC_BULK,
	parameter int CYC_SEG   = fpe_pkg::CYC_SEG,
	parameter int CYC_PAGE  = fpe_pkg::CYC_PAGE,
	parameter int CYC_ROW   = fpe_pkg::CYC_ROW,
	parameter int CYC_WORD  = fpe_pkg::CYC_WORD,
	parameter int CYC_CFG   = fpe_pkg::CYC_CFG
) (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               rst_n,
	// register port
	input  wire logic [fpe_pkg::ADDR_W-1:0]         reg_addr,
	input  wire logic [fpe_pkg::DATA_W-1:0]         reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [fpe_pkg::DATA_W-1:0]         reg_rdata,
	// table writes
	input  wire logic                               tbl_lo_wr,
	input  wire logic                               tbl_hi_wr,
	input  wire logic [fpe_pkg::TADDR_W-1:0]        tbl_addr,
	input  wire logic [fpe_pkg::DATA_W-1:0]         tbl_data,
	// flash array side
	output logic                                    flash_start,
	output logic                                    flash_erase,
	output logic      [fpe_pkg::OP_W-1:0]           flash_op,
	output logic      [fpe_pkg::TADDR_W-1:0]        flash_addr,
	input  wire logic [$clog2(BUF_DEPTH)-1:0]       flash_buf_idx,
	output logic      [fpe_pkg::INSTR_W-1:0]        flash_buf_data,
	// cpu side
	output logic                                    cpu_stall,
	output logic                                    irq
);
	import fpe_pkg::*;

	localparam int IDX_W = $clog2(BUF_DEPTH);

	// row alignment of the target address is fixed, so the buffer must span exactly one row
	if (BUF_DEPTH < 2 || (1 << IDX_W) != BUF_DEPTH || IDX_LSB + IDX_W != ROW_LSB) begin : g_chk_buf
		$error("fpe_flash_seq: buffer depth must be a power of two matching one row");
	end
	if (CYC_BULK < 1 || CYC_SEG < 1 || CYC_PAGE < 1 || CYC_ROW < 1 || CYC_WORD < 1 || CYC_CFG < 1 ||
	    CYC_BULK >= (1 << CNT_W) || CYC_SEG >= (1 << CNT_W) || CYC_PAGE >= (1 << CNT_W) ||
	    CYC_ROW >= (1 << CNT_W) || CYC_WORD >= (1 << CNT_W) || CYC_CFG >= (1 << CNT_W)) begin : g_chk_cyc
		$error("fpe_flash_seq: duration out of counter range");
	end

	// ==========================================
	// reset release
	logic [1:0] rs_q;
	logic       rst_sync_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rs_q[1];

	// ==========================================
	// op decode helpers
	function automatic logic op_valid(input logic er, input logic [OP_W-1:0] op);
		if (er) begin
			op_valid = (op == OP_BULK) || (op == OP_GEN_SEG) || (op == OP_SEC_SEG) ||
			           (op == OP_PAGE) || (op == OP_CFG);
		end else begin
			op_valid = (op == OP_WORD) || (op == OP_ROW) || (op == OP_CFG);
		end
	endfunction

	function automatic logic [CNT_W-1:0] op_cycles(input logic er, input logic [OP_W-1:0] op);
		op_cycles = CNT_W'(CYC_CFG);
		if (er) begin
			case (op)
				OP_BULK:    op_cycles = CNT_W'(CYC_BULK);
				OP_GEN_SEG: op_cycles = CNT_W'(CYC_SEG);
				OP_SEC_SEG: op_cycles = CNT_W'(CYC_SEG);
				OP_PAGE:    op_cycles = CNT_W'(CYC_PAGE);
				default:    op_cycles = CNT_W'(CYC_CFG);
			endcase
		end else begin
			case (op)
				OP_WORD: op_cycles = CNT_W'(CYC_WORD);
				OP_ROW:  op_cycles = CNT_W'(CYC_ROW);
				default: op_cycles = CNT_W'(CYC_CFG);
			endcase
		end
	endfunction

	// ==========================================
	// bus decode
	logic            wr_ctrl;
	logic            wr_key;
	logic            wr_stat;
	logic            wr_mask;
	logic            go_req;
	logic            new_permit;
	logic            new_erase;
	logic [OP_W-1:0] new_op;
	logic            armed;
	logic            start_ok;
	logic            fault_evt;
	logic            other_wr;

	logic            go_q;
	logic            go_d;
	logic            permit_q;
	logic            permit_d;
	logic            fault_q;
	logic            fault_d;
	logic            erase_q;
	logic            erase_d;
	logic [OP_W-1:0] op_q;
	logic [OP_W-1:0] op_d;

	assign wr_ctrl    = reg_wr && (reg_addr == OFS_CTRL);
	assign wr_key     = reg_wr && (reg_addr == OFS_KEY);
	assign wr_stat    = reg_wr && (reg_addr == OFS_STAT);
	assign wr_mask    = reg_wr && (reg_addr == OFS_MASK);
	assign go_req     = wr_ctrl && !go_q && reg_wdata[BIT_GO]; // [R19]
	assign new_permit = reg_wdata[BIT_PERMIT];
	assign new_erase  = reg_wdata[BIT_ERASE];
	assign new_op     = reg_wdata[OP_LSB +: OP_W];
	// key must directly precede go, so any other write drops the arming
	assign other_wr   = (reg_wr && !wr_key && !go_req) || tbl_lo_wr || tbl_hi_wr; // [R10]
	assign start_ok   = go_req && armed && new_permit && op_valid(new_erase, new_op); // [R04] [R17] [R18]
	assign fault_evt  = go_req && (!armed || !new_permit); // [R16]

	fpe_unlock u_unlock (
		.clk      (clk),
		.rst_n    (rst_sync_n),
		.key_wr   (wr_key && !go_q), // [R19]
		.key_data (reg_wdata[7:0]),
		.other_wr (other_wr),
		.consume  (go_req),
		.armed    (armed)
	);

	// ==========================================
	// operation timer
	fpe_op_if op_if ();

	assign op_if.start  = start_ok;
	assign op_if.cycles = op_cycles(new_erase, new_op); // [R19]

	fpe_timer #(
		.CW (CNT_W)
	) u_timer (
		.clk   (clk),
		.rst_n (rst_sync_n),
		.op    (op_if.tmr)
	);

	// ==========================================
	// control register
	always_comb begin
		go_d     = go_q;
		permit_d = permit_q;
		fault_d  = fault_q;
		erase_d  = erase_q;
		op_d     = op_q;
		if (wr_ctrl && !go_q) begin // [R19]
			permit_d = new_permit;
			erase_d  = new_erase;
			op_d     = new_op;
			fault_d  = reg_wdata[BIT_FAULT];
		end
		if (start_ok) begin
			go_d = 1'b1; // [R05]
		end
		if (go_q && op_if.done) begin
			go_d = 1'b0; // [R05] [R08]
		end
		if (fault_evt) begin
			fault_d = 1'b1; // [R16]
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			go_q     <= 1'b0;
			permit_q <= 1'b0;
			fault_q  <= 1'b0;
			erase_q  <= 1'b0;
			op_q     <= OP_RST;
		end else begin
			go_q     <= go_d;
			permit_q <= permit_d;
			fault_q  <= fault_d;
			erase_q  <= erase_d;
			op_q     <= op_d;
		end
	end

	assign cpu_stall = go_q; // [R05]

	// ==========================================
	// holding buffer and target address
	logic [INSTR_W-1:0] buf_q [BUF_DEPTH];
	logic [INSTR_W-1:0] buf_d [BUF_DEPTH];
	logic [IDX_W-1:0]   tbl_idx;
	logic [TADDR_W-1:0] tgt_q;
	logic [TADDR_W-1:0] tgt_d;
	logic [INSTR_W-1:0] rdbuf_q;
	logic [INSTR_W-1:0] rdbuf_d;

	assign tbl_idx = tbl_addr[IDX_LSB +: IDX_W];

	// buffer is frozen while an operation runs, the array may still be reading it
	always_comb begin
		buf_d   = buf_q;
		tgt_d   = tgt_q;
		rdbuf_d = buf_q[flash_buf_idx];
		if (!go_q) begin
			if (tbl_lo_wr) begin
				buf_d[tbl_idx][15:0] = tbl_data;
				tgt_d                = tbl_addr;
			end
			if (tbl_hi_wr) begin
				buf_d[tbl_idx][23:16] = tbl_data[7:0];
				tgt_d                 = tbl_addr;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				buf_q[i] <= '0;
			end
			tgt_q   <= '0;
			rdbuf_q <= '0;
		end else begin
			buf_q   <= buf_d;
			tgt_q   <= tgt_d;
			rdbuf_q <= rdbuf_d;
		end
	end

	assign flash_buf_data = rdbuf_q;

	// ==========================================
	// flash command outputs
	logic               fstart_q;
	logic               ferase_q;
	logic [OP_W-1:0]    fop_q;
	logic [TADDR_W-1:0] faddr_q;
	logic [TADDR_W-1:0] faddr_d;

	always_comb begin
		faddr_d = faddr_q;
		if (start_ok) begin
			faddr_d = tgt_q;
			if (new_erase && new_op == OP_PAGE) begin
				faddr_d[PAGE_LSB-1:0] = '0;
			end else if (!new_erase && new_op == OP_ROW) begin
				faddr_d[ROW_LSB-1:0] = '0; // [R08]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fstart_q <= 1'b0;
			ferase_q <= 1'b0;
			fop_q    <= OP_RST;
			faddr_q  <= '0;
		end else begin
			fstart_q <= start_ok;
			ferase_q <= start_ok ? new_erase : ferase_q;
			fop_q    <= start_ok ? new_op : fop_q;
			faddr_q  <= faddr_d;
		end
	end

	assign flash_start = fstart_q;
	assign flash_erase = ferase_q;
	assign flash_op    = fop_q;
	assign flash_addr  = faddr_q;

	// ==========================================
	// status, mask, interrupt and read data
	logic [1:0]        stat_q;
	logic [1:0]        stat_d;
	logic [1:0]        mask_q;
	logic [1:0]        mask_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [1:0]        stat_set;

	assign stat_set = {fault_evt, go_q && op_if.done};

	always_comb begin
		stat_d  = stat_q;
		mask_d  = mask_q;
		rdata_d = '0;
		if (wr_stat) begin
			stat_d = stat_q & ~reg_wdata[1:0];
		end
		stat_d = stat_d | stat_set;
		if (wr_mask) begin
			mask_d = reg_wdata[1:0];
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: rdata_d = {go_q, permit_q, fault_q, 6'h00, erase_q, 2'h0, op_q};
				OFS_STAT: rdata_d = {14'h0000, stat_q};
				OFS_MASK: rdata_d = {14'h0000, mask_q};
				default:  rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stat_q  <= STAT_RST;
			mask_q  <= MASK_RST;
			rdata_q <= '0;
		end else begin
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = |(stat_q & mask_q);

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	go_start_a: assert property (start_ok |=> go_q && cpu_stall && flash_start && op_if.busy) // [R05]
		else $error("go not set after valid start");
	go_clear_a: assert property (go_q && op_if.done |=> !go_q && stat_q[ST_DONE]) // [R08]
		else $error("go not cleared at operation end");
	key_need_a: assert property (go_req && !armed |=> !go_q && fault_q) // [R04]
		else $error("go accepted without key");
	key_fresh_a: assert property ($rose(go_q) |-> $past(armed && go_req)) // [R10]
		else $error("operation without fresh key");
	fault_set_a: assert property (go_req && !new_permit |=> fault_q && stat_q[ST_FAULT]) // [R16]
		else $error("fault not flagged");
	permit_gate_a: assert property ($rose(go_q) |-> permit_q) // [R17]
		else $error("operation ran with permit clear");
	nop_code_a: assert property (go_req && !op_valid(new_erase, new_op) |=> !go_q && !flash_start) // [R18]
		else $error("unlisted code started");
	busy_lock_a: assert property (go_q && reg_wr |=> $stable(op_q) && $stable(permit_q) && !flash_start) // [R19]
		else $error("control changed while busy");

	erase_run_c: cover property (start_ok && new_erase && new_op == OP_PAGE ##1 go_q);
	row_run_c: cover property (start_ok && !new_erase && new_op == OP_ROW);
	fault_c: cover property (fault_evt);
	irq_c: cover property ($rose(irq));

endmodule

`default_nettype wire

/* core/fpe_pkg.sv */
/*
 * constants, field layout, op codes and state types of the flash page erase / row program sequencer
 * assumes a single system clock and a plain register port with word offsets
 */
package fpe_pkg;

	// ==========================================
	// widths
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 16;
	localparam int TADDR_W   = 24;
	localparam int INSTR_W   = 24;
	localparam int CNT_W     = 16;
	localparam int BUF_DEPTH = 64;
	localparam int IDX_LSB   = 1;
	localparam int ROW_LSB   = 7;
	localparam int PAGE_LSB  = 10;

	// ==========================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_KEY  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_STAT = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_MASK = 4'h3;

	// ==========================================
	// control register fields and reset values
	localparam int BIT_GO     = 15;
	localparam int BIT_PERMIT = 14;
	localparam int BIT_FAULT  = 13;
	localparam int BIT_ERASE  = 6;
	localparam int OP_LSB     = 0;
	localparam int OP_W       = 4;
	localparam logic [OP_W-1:0] OP_RST   = 4'h0;
	localparam logic [1:0]      STAT_RST = 2'h0;
	localparam logic [1:0]      MASK_RST = 2'h0;
	localparam int ST_DONE  = 0;
	localparam int ST_FAULT = 1;

	// ==========================================
	// unlock keys and op codes
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [OP_W-1:0] OP_BULK    = 4'hF;
	localparam logic [OP_W-1:0] OP_GEN_SEG = 4'hD;
	localparam logic [OP_W-1:0] OP_SEC_SEG = 4'hC;
	localparam logic [OP_W-1:0] OP_WORD    = 4'h3;
	localparam logic [OP_W-1:0] OP_PAGE    = 4'h2;
	localparam logic [OP_W-1:0] OP_ROW     = 4'h1;
	localparam logic [OP_W-1:0] OP_CFG     = 4'h0;

	// ==========================================
	// self-timed durations in clock cycles
	localparam int CYC_BULK = 8192;
	localparam int CYC_SEG  = 6144;
	localparam int CYC_PAGE = 4096;
	localparam int CYC_ROW  = 2048;
	localparam int CYC_WORD = 256;
	localparam int CYC_CFG  = 128;

	// ==========================================
	// state types
	typedef enum logic [1:0] {FPE_LOCKED, FPE_HALF, FPE_ARMED} fpe_key_type;

endpackage

/* core/fpe_op_if.sv */
/*
 * interface between the sequencer control and its operation timer
 * assumes both ends sit on the same clock
 */
`timescale 1ns/1ps
`default_nettype none

interface fpe_op_if;
	import fpe_pkg::*;
	logic             start;
	logic [CNT_W-1:0] cycles;
	logic             done;
	logic             busy;
	modport ctl (output start, output cycles, input done, input busy);
	modport tmr (input start, input cycles, output done, output busy);
endinterface

`default_nettype wire

/* core/fpe_timer.sv */
/*
 * self-timed operation counter: counts a loaded number of cycles, then pulses done
 * assumes cycles is at least one when start is given
 */
`timescale 1ns/1ps
`default_nettype none

module fpe_timer #(
	parameter int CW = fpe_pkg::CNT_W
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// operation handshake
	fpe_op_if.tmr     op
);
	import fpe_pkg::*;

	// the load slice below cannot serve a counter wider than the cycles field
	if (CW < 2 || CW > CNT_W) begin : g_chk
		$error("fpe_timer: counter width out of range");
	end

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          busy_q;
	logic          busy_d;
	logic          done_q;
	logic          done_d;

	// ==========================================
	// counter
	always_comb begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (!busy_q && op.start) begin
			busy_d = 1'b1;
			cnt_d  = op.cycles[CW-1:0];
		end else if (busy_q) begin
			if (cnt_q <= 1) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				cnt_d  = '0;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign op.busy = busy_q;
	assign op.done = done_q;

	tmr_end_a: assert property (@(posedge clk) disable iff (!rst_n) busy_q && cnt_q == 1 |=> done_q && !busy_q) // [R19]
		else $error("timer did not finish on last count");

endmodule

`default_nettype wire

/* core/fpe_unlock.sv */
/*
 * unlock key tracker: first key then second key arms one operation
 * assumes the caller reports every other register or table write as other_wr
 */
`timescale 1ns/1ps
`default_nettype none

module fpe_unlock (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// key events
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	input  wire logic       other_wr,
	input  wire logic       consume,
	// state
	output logic            armed
);
	import fpe_pkg::*;

	fpe_key_type st_q;
	fpe_key_type st_d;

	// ==========================================
	// sequence tracking
	always_comb begin
		st_d = st_q;
		if (consume || other_wr) begin
			st_d = FPE_LOCKED; // [R10]
		end else if (key_wr) begin
			case (st_q)
				FPE_HALF: begin
					st_d = (key_data == KEY_SECOND) ? FPE_ARMED :
					       (key_data == KEY_FIRST) ? FPE_HALF : FPE_LOCKED; // [R04]
				end
				default: begin
					st_d = (key_data == KEY_FIRST) ? FPE_HALF : FPE_LOCKED;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= FPE_LOCKED;
		end else begin
			st_q <= st_d;
		end
	end

	assign armed = (st_q == FPE_ARMED);

	arm_order_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(armed) |-> $past(key_wr && key_data == KEY_SECOND)) // [R04]
		else $error("armed without second key");

endmodule

`default_nettype wire

/* sim/tb_fpe_flash_seq.sv */
/*
 * self-checking bench of the flash page erase / row program sequencer
 * assumes the design package and interface are compiled first; durations shortened by parameters
 */
`timescale 1ns/1ps
`default_nettype none

module tb_fpe_flash_seq;
	import fpe_pkg::*;

	// ==========================================
	// shortened durations, all distinct so a wrong lookup shows
	localparam int C_BULK = 9;
	localparam int C_SEG  = 7;
	localparam int C_PAGE = 6;
	localparam int C_ROW  = 5;
	localparam int C_WORD = 4;
	localparam int C_CFG  = 3;

	logic                 clk;
	logic                 rst_n;
	logic [ADDR_W-1:0]    reg_addr;
	logic [DATA_W-1:0]    reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [DATA_W-1:0]    reg_rdata;
	logic                 tbl_lo_wr;
	logic                 tbl_hi_wr;
	logic [TADDR_W-1:0]   tbl_addr;
	logic [DATA_W-1:0]    tbl_data;
	logic                 flash_start;
	logic                 flash_erase;
	logic [OP_W-1:0]      flash_op;
	logic [TADDR_W-1:0]   flash_addr;
	logic [5:0]           flash_buf_idx;
	logic [INSTR_W-1:0]   flash_buf_data;
	logic                 cpu_stall;
	logic                 irq;
	logic [1:0]           mask_v;
	int                   errors;
	int                   n_tests;

	fpe_flash_seq #(
		.BUF_DEPTH(64), .CYC_BULK(C_BULK), .CYC_SEG(C_SEG), .CYC_PAGE(C_PAGE),
		.CYC_ROW(C_ROW), .CYC_WORD(C_WORD), .CYC_CFG(C_CFG)
	) i_dut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tbl_lo_wr(tbl_lo_wr), .tbl_hi_wr(tbl_hi_wr), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
		.flash_start(flash_start), .flash_erase(flash_erase), .flash_op(flash_op),
		.flash_addr(flash_addr), .flash_buf_idx(flash_buf_idx), .flash_buf_data(flash_buf_data),
		.cpu_stall(cpu_stall), .irq(irq)
	);

	// ==========================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#(20 * 20000);
		errors++;
		final_report();
	end

	// ==========================================
	// bus tasks and compare
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// table write: hi selects the high-byte store
	task automatic tw(input logic hi, input logic [23:0] a, input logic [15:0] d);
		@(posedge clk);
		tbl_lo_wr <= ~hi;
		tbl_hi_wr <= hi;
		tbl_addr  <= a;
		tbl_data  <= d;
		@(posedge clk);
		tbl_lo_wr <= 1'b0;
		tbl_hi_wr <= 1'b0;
		#1;
	endtask

	// read back control and status, check irq, then clear both
	task automatic fin(input logic [15:0] ectrl, input logic [1:0] estat);
		logic [15:0] v;
		rd(OFS_CTRL, v);
		chk("ctrl", {8'h00, ectrl}, {8'h00, v});
		rd(OFS_STAT, v);
		chk("stat", {22'h0, estat}, {8'h00, v});
		chk("irq", 24'(|(estat & mask_v)), 24'(irq));
		wr(OFS_STAT, 16'h0003);
		wr(OFS_CTRL, 16'h0000);
		chk("irq cleared", 24'h0, 24'(irq));
	endtask

	// setup, key pair, go; n is the expected duration, 0 when nothing may start
	task automatic do_op(input logic [15:0] c, input int n, input logic [15:0] ectrl,
			input logic [1:0] estat);
		int cnt;
		wr(OFS_CTRL, c & 16'h7FFF);
		wr(OFS_KEY, 16'h0055);
		wr(OFS_KEY, 16'h00AA);
		wr(OFS_CTRL, c);
		chk("start", 24'(n > 0), 24'(flash_start));
		cnt = 0;
		while (cpu_stall === 1'b1 && cnt < 200) begin
			cnt++;
			@(posedge clk);
			#1;
		end
		chk("stall cycles", 24'(n > 0 ? n + 1 : 0), 24'(cnt));
		if (n > 0) begin
			chk("erase sel", 24'(c[BIT_ERASE]), 24'(flash_erase));
			chk("op", 24'(c[3:0]), 24'(flash_op));
		end
		fin(ectrl, estat);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [15:0] v;
		logic [3:0]  a;
		for (int i = 0; i < 5; i++) begin
			a = (i == 4) ? 4'h9 : 4'(i);
			rd(a, v);
			chk("reset reg", 24'h0, {8'h00, v});
		end
		chk("reset stall", 24'h0, 24'(cpu_stall));
	endtask

	// every listed code, plus two codes that must do nothing
	task automatic t_codes();
		logic [4:0] code [10] = '{5'h1F, 5'h1D, 5'h1C, 5'h12, 5'h10, 5'h03, 5'h01, 5'h00, 5'h13, 5'h0F};
		int         dur  [10] = '{C_BULK, C_SEG, C_SEG, C_PAGE, C_CFG, C_WORD, C_ROW, C_CFG, 0, 0};
		logic [15:0] c;
		for (int i = 0; i < 10; i++) begin
			c = 16'hC000 | (16'(code[i][4]) << 6) | 16'(code[i][3:0]);
			do_op(c, dur[i], c & 16'h7FFF, dur[i] > 0 ? 2'h1 : 2'h0);
		end
	endtask

	task automatic t_page();
		tw(1'b0, 24'h006A46, 16'h1234);
		do_op(16'hC042, C_PAGE, 16'h4042, 2'h1);
		chk("page addr", 24'h006800, flash_addr);
	endtask

	task automatic t_row();
		// row lies inside the page erased just before
		tw(1'b0, 24'h006A80, 16'hBEEF);
		tw(1'b1, 24'h006A80, 16'h00A5);
		tw(1'b0, 24'h006AFE, 16'h4321);
		tw(1'b1, 24'h006AFE, 16'h005A);
		@(posedge clk);
		flash_buf_idx <= 6'h00;
		@(posedge clk);
		flash_buf_idx <= 6'h3F;
		#1;
		chk("buf 0", 24'hA5BEEF, flash_buf_data);
		@(posedge clk);
		#1;
		chk("buf 63", 24'h5A4321, flash_buf_data);
		do_op(16'hC001, C_ROW, 16'h4001, 2'h1);
		chk("row addr", 24'h006A80, flash_addr);
	endtask

	task automatic t_faults();
		mask_v = 2'h3;
		wr(OFS_MASK, 16'h0003);
		wr(OFS_CTRL, 16'h4042);
		wr(OFS_CTRL, 16'hC042);
		chk("no key stall", 24'h0, 24'(cpu_stall));
		fin(16'h6042, 2'h2);
		wr(OFS_KEY, 16'h0055);
		wr(OFS_STAT, 16'h0000);
		wr(OFS_KEY, 16'h00AA);
		wr(OFS_CTRL, 16'hC042);
		fin(16'h6042, 2'h2);
		wr(OFS_KEY, 16'h0055);
		wr(OFS_KEY, 16'h0012);
		wr(OFS_KEY, 16'h00AA);
		wr(OFS_CTRL, 16'hC001);
		fin(16'h6001, 2'h2);
		do_op(16'h8042, 0, 16'h2042, 2'h2);
		do_op(16'hC001, C_ROW, 16'h4001, 2'h1);
		mask_v = 2'h0;
		wr(OFS_MASK, 16'h0000);
	endtask

	// control and key writes during a running operation are dropped
	task automatic t_busy();
		logic [15:0] v;
		wr(OFS_CTRL, 16'h404F);
		wr(OFS_KEY, 16'h0055);
		wr(OFS_KEY, 16'h00AA);
		wr(OFS_CTRL, 16'hC04F);
		repeat (2) @(posedge clk);
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_KEY, 16'h0055);
		rd(OFS_CTRL, v);
		chk("ctrl busy", 24'h00C04F, {8'h00, v});
		for (int i = 0; i < 40 && cpu_stall === 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		fin(16'h404F, 2'h1);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		errors = 0;
		n_tests = 0;
		mask_v = 2'h0;
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tbl_lo_wr = 1'b0;
		tbl_hi_wr = 1'b0;
		tbl_addr = '0;
		tbl_data = '0;
		flash_buf_idx = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_codes();
		t_page();
		t_row();
		t_faults();
		t_busy();
		final_report();
	end

endmodule

`default_nettype wire
